// ---- sdms_pkg.sv ----
// package for the step/direction microstep sequencer: register map, fields, state record
package sdms_pkg;

    // ****************************************************************
    // register map (byte addresses on the wishbone bus)
    // ****************************************************************
    localparam logic [7:0] ADR_CTRL      = 8'h00;
    localparam logic [7:0] ADR_CURRENT   = 8'h04;
    localparam logic [7:0] ADR_STATUS    = 8'h08;
    localparam logic [7:0] ADR_INT_STAT  = 8'h0c;
    localparam logic [7:0] ADR_INT_MASK  = 8'h10;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int CTRL_DEDGE_BIT    = 0;
    localparam int CTRL_INTPOL_BIT   = 1;
    localparam int CTRL_FASTSTST_BIT = 2;
    localparam int CTRL_RAMPOFF_BIT  = 3;
    localparam int CTRL_MRES_LSB     = 4;
    localparam int CUR_RUN_LSB       = 0;
    localparam int CUR_HOLD_LSB      = 8;
    localparam int STAT_STST_BIT     = 16;
    localparam int STAT_SCALE_LSB    = 24;
    localparam int EV_STST_BIT       = 0;
    localparam int EV_STEP_BIT       = 1;
    localparam int EV_SKIP_BIT       = 2;

    // ****************************************************************
    // sizes and counts
    // ****************************************************************
    localparam int          MS_W       = 10;     // 1024 table positions
    localparam int          MRES_W     = 4;
    localparam int          CUR_W      = 5;
    localparam int          EV_W       = 3;
    localparam int          SINCE_W    = 21;     // holds up to 2^20
    localparam int          IVL_W      = 13;     // 2^20 / 256
    localparam int          REM_W      = 9;      // up to 256 microsteps
    localparam int          IVL_SHIFT  = 8;      // one period split in 256 parts
    localparam logic [3:0]  MRES_FULL  = 4'h8;   // full step, width 256
    localparam int          STST_CLKS_DEF      = 2**20;
    localparam int          STST_FAST_CLKS_DEF = 2**18;

    // ****************************************************************
    // complete state of the sequencer
    // ****************************************************************
    typedef struct packed {
        logic                step_meta;
        logic                step_sync;
        logic                step_prev;
        logic                dir_meta;
        logic                dir_sync;
        logic                dedge;
        logic                intpol;
        logic                intpol_old;
        logic                fast_stst;
        logic                ramp_off;
        logic [MRES_W-1:0]   mres;
        logic [MRES_W-1:0]   mres_old;
        logic [CUR_W-1:0]    run_current;
        logic [CUR_W-1:0]    hold_current;
        logic [CUR_W-1:0]    cur_scale;
        logic [MS_W-1:0]     mscnt;
        logic [SINCE_W-1:0]  since;
        logic [IVL_W-1:0]    interval;
        logic [IVL_W-1:0]    tick;
        logic [REM_W-1:0]    remain;
        logic                run_dir;
        logic                stst;
        logic [EV_W-1:0]     int_stat;
        logic [EV_W-1:0]     int_mask;
        logic                irq;
        logic                ack;
        logic [31:0]         dat;
    } sdms_state_s;

endpackage : sdms_pkg

// ---- sdms_sequencer.sv ----
// step/direction front end with microstep counter, interpolator and standstill detection
`timescale 1ns/1ns

module sdms_sequencer #(
    parameter int STST_CLKS      = sdms_pkg::STST_CLKS_DEF,       // idle clocks to standstill
    parameter int STST_FAST_CLKS = sdms_pkg::STST_FAST_CLKS_DEF   // same, fast mode
) (
    input  wire logic        clk_i,            // system clock, 125 MHz
    input  wire logic        rst_i,            // synchronous reset, high
    input  wire logic        step_i,           // step pin, asynchronous
    input  wire logic        dir_i,            // direction pin, asynchronous
    input  wire logic        wb_cyc_i,         // wishbone cycle
    input  wire logic        wb_stb_i,         // wishbone strobe
    input  wire logic        wb_we_i,          // wishbone write enable
    input  wire logic [7:0]  wb_adr_i,         // wishbone byte address
    input  wire logic [3:0]  wb_sel_i,         // wishbone byte selects
    input  wire logic [31:0] wb_dat_i,         // wishbone write data
    output logic      [31:0] wb_dat_o,         // wishbone read data
    output logic             wb_ack_o,         // wishbone acknowledge
    output logic      [9:0]  mscnt_o,          // microstep table position
    output logic      [4:0]  current_scale_o,  // selected coil current
    output logic             standstill_o,     // standstill flag
    output logic             ramp_off_o,       // internal ramp generator disabled
    output logic             irq_o             // level interrupt
);

    // ****************************************************************
    // parameter checks
    // ****************************************************************
    if (STST_CLKS < 2 || STST_CLKS > 2**20 || STST_FAST_CLKS < 2 || STST_FAST_CLKS > STST_CLKS) begin : g_bad_param
        $error("standstill counts out of range");
    end

    localparam logic [sdms_pkg::SINCE_W-1:0] LIM_SLOW = sdms_pkg::SINCE_W'(STST_CLKS);
    localparam logic [sdms_pkg::SINCE_W-1:0] LIM_FAST = sdms_pkg::SINCE_W'(STST_FAST_CLKS);
    localparam logic [sdms_pkg::SINCE_W-1:0] SINCE_MAX = sdms_pkg::SINCE_W'(2**20);

    // ****************************************************************
    // helper functions
    // ****************************************************************
    // step width from resolution code, codes above full step clamp
    function automatic logic [9:0] step_width(input logic [3:0] mres);
        logic [3:0] m;
        m = (mres > sdms_pkg::MRES_FULL) ? sdms_pkg::MRES_FULL : mres;
        return 10'(10'h001 << m);
    endfunction : step_width

    // nearest valid position for a resolution: centre of its width slot
    function automatic logic [9:0] snap_pos(input logic [9:0] cnt, input logic [3:0] mres);
        logic [9:0] w;
        w = step_width(mres);
        if (w == 10'h001) begin
            return cnt;
        end
        return (cnt & ~(w - 10'h001)) | (w >> 1);
    endfunction : snap_pos

    // move the counter, wrapping modulo 1024 in both directions
    function automatic logic [9:0] move(input logic [9:0] cnt, input logic [9:0] amt, input logic dir);
        return dir ? 10'(cnt - amt) : 10'(cnt + amt);
    endfunction : move

    // byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (wd & m);
    endfunction : merge

    // ****************************************************************
    // state
    // ****************************************************************
    sdms_pkg::sdms_state_s s_q;
    sdms_pkg::sdms_state_s s_d;
    logic                  act;          // active step edge this cycle
    logic                  coarser;      // resolution just lowered
    logic                  intpol_off;   // interpolator just disabled
    logic [9:0]            width;        // current step width
    logic [31:0]           ctrl_rd;
    logic [31:0]           cur_rd;
    logic [31:0]           stat_rd;

    // register views for reads; the control and current views also feed the write merge
    assign ctrl_rd = {24'h000000, s_q.mres, s_q.ramp_off, s_q.fast_stst, s_q.intpol, s_q.dedge};
    assign cur_rd  = {19'h00000, s_q.hold_current, 3'h0, s_q.run_current};
    assign stat_rd = {3'h0, s_q.cur_scale, 7'h00, s_q.stst, 6'h00, s_q.mscnt};

    // edge selection works on the second synchroniser stage only
    assign act = (s_q.step_sync & ~s_q.step_prev) | (s_q.dedge & ~s_q.step_sync & s_q.step_prev);
    assign coarser    = s_q.mres > s_q.mres_old;
    assign intpol_off = s_q.intpol_old & ~s_q.intpol;
    assign width      = step_width(s_q.mres);

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb begin
        logic [sdms_pkg::SINCE_W-1:0] lim;
        logic [sdms_pkg::EV_W-1:0]    ev;
        logic [sdms_pkg::EV_W-1:0]    clr;
        logic [31:0]                  wv;
        logic                         wr;
        lim = '0;
        ev  = '0;
        clr = '0;
        wv  = '0;
        wr  = 1'b0;
        s_d = s_q;

        // two-stage synchronisers; the first stage feeds only the second
        s_d.step_meta  = step_i;
        s_d.step_sync  = s_q.step_meta;
        s_d.step_prev  = s_q.step_sync;
        s_d.dir_meta   = dir_i;
        s_d.dir_sync   = s_q.dir_meta;
        s_d.mres_old   = s_q.mres;
        s_d.intpol_old = s_q.intpol;

        // idle clock count doubles as the step period measurement
        if (act) begin
            s_d.since = '0;
        end else if (s_q.since < SINCE_MAX) begin
            s_d.since = s_q.since + 1'b1;
        end

        // standstill: set on idle limit, cleared by an active edge
        lim = s_q.fast_stst ? LIM_FAST : LIM_SLOW;
        if (act) begin
            s_d.stst = 1'b0;
        end else if (s_d.since >= lim) begin
            s_d.stst = 1'b1;
        end
        ev[sdms_pkg::EV_STST_BIT] = s_d.stst & ~s_q.stst;
        ev[sdms_pkg::EV_STEP_BIT] = act;
        s_d.cur_scale = s_d.stst ? s_q.hold_current : s_q.run_current;

        // microstep counter; a change to a coarser resolution or disabling the interpolator takes precedence over a step in the same cycle
        if (coarser || intpol_off) begin
            s_d.mscnt  = snap_pos(s_q.mscnt, s_q.mres);
            s_d.remain = '0;
        end else if (act && s_q.intpol) begin
            // leftover microsteps of a shortened period are taken at once as a jump
            s_d.mscnt = move(s_q.mscnt, 10'(s_q.remain), s_q.run_dir);
            ev[sdms_pkg::EV_SKIP_BIT] = s_q.remain != '0;
            s_d.remain   = 9'(width);
            s_d.run_dir  = s_q.dir_sync;
            s_d.interval = (s_q.since[sdms_pkg::SINCE_W-1:sdms_pkg::IVL_SHIFT] == '0) ? 13'h0001 :
                           s_q.since[sdms_pkg::SINCE_W-1:sdms_pkg::IVL_SHIFT];
            s_d.tick     = s_d.interval;
        end else if (act) begin
            s_d.mscnt = move(s_q.mscnt, width, s_q.dir_sync);
        end else if (s_q.intpol && s_q.remain != '0) begin
            if (s_q.tick <= 13'h0001) begin
                s_d.mscnt  = move(s_q.mscnt, 10'h001, s_q.run_dir);
                s_d.remain = s_q.remain - 1'b1;
                s_d.tick   = s_q.interval;
            end else begin
                s_d.tick = s_q.tick - 1'b1;
            end
        end
        if (!s_q.intpol) begin
            s_d.remain = '0;
        end

        // wishbone classic slave: ack one cycle after the request, write commits at the acked edge
        s_d.ack = wb_cyc_i & wb_stb_i & ~s_q.ack;
        if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
            case (wb_adr_i)
                sdms_pkg::ADR_CTRL:     s_d.dat = ctrl_rd;
                sdms_pkg::ADR_CURRENT:  s_d.dat = cur_rd;
                sdms_pkg::ADR_STATUS:   s_d.dat = stat_rd;
                sdms_pkg::ADR_INT_STAT: s_d.dat = {29'h0, s_q.int_stat};
                sdms_pkg::ADR_INT_MASK: s_d.dat = {29'h0, s_q.int_mask};
                default:                s_d.dat = 32'h0000_0000;
            endcase
        end
        wr = wb_cyc_i & wb_stb_i & wb_we_i & s_q.ack;
        if (wr) begin
            case (wb_adr_i)
                sdms_pkg::ADR_CTRL: begin
                    wv = merge(ctrl_rd, wb_dat_i, wb_sel_i);
                    s_d.dedge     = wv[sdms_pkg::CTRL_DEDGE_BIT];
                    s_d.intpol    = wv[sdms_pkg::CTRL_INTPOL_BIT];
                    s_d.fast_stst = wv[sdms_pkg::CTRL_FASTSTST_BIT];
                    s_d.ramp_off  = wv[sdms_pkg::CTRL_RAMPOFF_BIT];
                    s_d.mres      = wv[sdms_pkg::CTRL_MRES_LSB +: sdms_pkg::MRES_W];
                end
                sdms_pkg::ADR_CURRENT: begin
                    wv = merge(cur_rd, wb_dat_i, wb_sel_i);
                    s_d.run_current  = wv[sdms_pkg::CUR_RUN_LSB +: sdms_pkg::CUR_W];
                    s_d.hold_current = wv[sdms_pkg::CUR_HOLD_LSB +: sdms_pkg::CUR_W];
                end
                sdms_pkg::ADR_INT_STAT: begin
                    if (wb_sel_i[0]) begin
                        clr = wb_dat_i[sdms_pkg::EV_W-1:0];
                    end
                end
                sdms_pkg::ADR_INT_MASK: begin
                    if (wb_sel_i[0]) begin
                        s_d.int_mask = wb_dat_i[sdms_pkg::EV_W-1:0];
                    end
                end
                default: begin
                    wv = '0;
                end
            endcase
        end

        // sticky events: a new event wins over a clear in the same cycle
        s_d.int_stat = (s_q.int_stat & ~clr) | ev;
        s_d.irq      = |(s_d.int_stat & s_d.int_mask);
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign wb_dat_o        = s_q.dat;
    assign wb_ack_o        = s_q.ack;
    assign mscnt_o         = s_q.mscnt;
    assign current_scale_o = s_q.cur_scale;
    assign standstill_o    = s_q.stst;
    assign ramp_off_o      = s_q.ramp_off;
    assign irq_o           = s_q.irq;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // a plain step: active edge with interpolation off and not just disabled, and no change to a coarser resolution
    sequence s_plain_step;
        act && !s_q.intpol && !coarser && !intpol_off;
    endsequence

    a_sync_two_stage: assert property (s_q.step_sync == $past(step_i, 2)) else $error("step sync depth wrong");
    a_single_edge: assert property (!s_q.dedge && !s_q.step_sync && s_q.step_prev |-> !act) else $error("falling edge counted");
    a_step_forward: assert property (s_plain_step ##0 !s_q.dir_sync |=> mscnt_o == 10'($past(s_q.mscnt) + $past(width)))
        else $error("forward step wrong");
    a_step_reverse: assert property (s_plain_step ##0 s_q.dir_sync |=> mscnt_o == 10'($past(s_q.mscnt) - $past(width)))
        else $error("reverse step wrong");
    a_snap_valid: assert property (coarser && width != 10'h001 |=> (mscnt_o & ($past(width) - 10'h001)) == ($past(width) >> 1))
        else $error("snap off grid");
    a_full_grid: assert property (s_q.mres == sdms_pkg::MRES_FULL && $past(s_q.mres) == sdms_pkg::MRES_FULL && !s_q.intpol
        && !$past(s_q.intpol) && !$past(coarser) |-> mscnt_o[7:0] == 8'h80) else $error("full step off grid");
    a_interp_load: assert property (act && s_q.intpol && !coarser && !intpol_off |=> s_q.remain == 9'($past(width)))
        else $error("interpolation run length wrong");
    a_interp_off: assert property (!s_q.intpol |=> s_q.remain == '0) else $error("interpolator active while off");
    a_stst_set: assert property (!act && !s_q.stst && s_q.since + 1'b1 >= (s_q.fast_stst ? LIM_FAST : LIM_SLOW) |=> standstill_o)
        else $error("standstill late");
    a_stst_clear: assert property (s_q.stst && act |=> !standstill_o) else $error("standstill not cleared");
    a_hold_current: assert property (standstill_o |=> standstill_o |-> current_scale_o == $past(s_q.hold_current))
        else $error("hold current not selected");

endmodule : sdms_sequencer

// ---- sdms_sequencer_tb_top.sv ----
// testbench: register access, stepping, snapping, interpolation and standstill
`timescale 1ns/1ns

module sdms_sequencer_tb_top;
    logic        clk_i;
    logic        rst_i;
    logic        step_i;
    logic        dir_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [9:0]  mscnt_o;
    logic [4:0]  current_scale_o;
    logic        standstill_o;
    logic        ramp_off_o;
    logic        irq_o;
    int          miscompares;
    int          comparisons;
    logic [9:0]  exp_cnt;
    logic [9:0]  w;
    logic [31:0] rd;

    // free-running 125 MHz clock
    always #4 clk_i = ~clk_i;

    sdms_stepgen ctl_u (.clk_i(clk_i), .step_o(step_i), .dir_o(dir_i));

    // small standstill counts keep the run short
    sdms_sequencer #(.STST_CLKS(512), .STST_FAST_CLKS(16)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .step_i(step_i), .dir_i(dir_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .mscnt_o(mscnt_o), .current_scale_o(current_scale_o), .standstill_o(standstill_o),
        .ramp_off_o(ramp_off_o), .irq_o(irq_o));

    // ****************************************************************
    // checking and bus tasks
    // ****************************************************************
    task automatic report_and_stop();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit

    // classic single cycle; request held until ack is sampled, then released
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            miscompares++;
            report_and_stop();
        end
    endtask : xfer

    // two edges let a snap or a counted edge land before sampling
    task automatic settle();
        repeat (2) @(negedge clk_i);
    endtask : settle

    task automatic wait_stst(input int bound);
        int n;
        n = 0;
        while (standstill_o !== 1'b1 && n < bound) begin
            @(posedge clk_i);
            n++;
        end
        if (standstill_o !== 1'b1) begin
            miscompares++;
            report_and_stop();
        end
    endtask : wait_stst

    // ****************************************************************
    // main sequence
    // ****************************************************************
    // expected counter is tracked modulo 1024 in a 10-bit variable
    initial begin
        clk_i = 1'b0; rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
        wb_adr_i = 8'h00; wb_sel_i = 4'h0; wb_dat_i = 32'h0; miscompares = 0; comparisons = 0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        xfer(1'b0, sdms_pkg::ADR_STATUS, 32'h0, rd);
        chk_word(rd, 32'h0);
        xfer(1'b1, sdms_pkg::ADR_STATUS, 32'hffffffff, rd);
        xfer(1'b0, sdms_pkg::ADR_STATUS, 32'h0, rd);
        chk_word(rd & 32'h3ff, 32'h0);
        xfer(1'b1, 8'h14, 32'hffffffff, rd);
        xfer(1'b0, sdms_pkg::ADR_CTRL, 32'h0, rd);
        chk_word(rd, 32'h0);
        xfer(1'b0, sdms_pkg::ADR_INT_MASK, 32'h0, rd);
        chk_word(rd, 32'h0);
        xfer(1'b0, 8'h14, 32'h0, rd);
        chk_word(rd, 32'h0);
        xfer(1'b1, sdms_pkg::ADR_CURRENT, 32'h0000030a, rd);
        xfer(1'b0, sdms_pkg::ADR_CURRENT, 32'h0, rd);
        chk_word(rd, 32'h0000030a);
        // each coarser resolution snaps, then one step moves by its width
        exp_cnt = 10'h0;
        for (int m = 0; m <= 8; m++) begin
            w = 10'h1 << m;
            xfer(1'b1, sdms_pkg::ADR_CTRL, 32'(m) << 4, rd);
            exp_cnt = (exp_cnt & ~(w - 10'h1)) | (w >> 1);
            settle();
            chk_word(32'(mscnt_o), 32'(exp_cnt));
            ctl_u.pulse(1'b0, 4);
            exp_cnt = exp_cnt + w;
            settle();
            chk_word(32'(mscnt_o), 32'(exp_cnt));
        end
        // downward full steps wrap below zero
        repeat (2) begin
            ctl_u.pulse(1'b1, 4);
            exp_cnt = exp_cnt - 10'h100;
            settle();
            chk_word(32'(mscnt_o), 32'(exp_cnt));
        end
        // both edges active, ramp off leaves current settings in force
        xfer(1'b1, sdms_pkg::ADR_CTRL, 32'h89, rd);
        settle();
        chk_bit(ramp_off_o, 1'b1);
        ctl_u.pulse(1'b0, 4);
        exp_cnt = exp_cnt + 10'h200;
        settle();
        chk_word(32'(mscnt_o), 32'(exp_cnt));
        chk_word(32'(current_scale_o), 32'h0a);
        repeat (400) @(posedge clk_i);
        chk_bit(standstill_o, 1'b0);
        wait_stst(120);
        settle();
        chk_word(32'(current_scale_o), 32'h03);
        // standstill event masked in, step event masked out
        xfer(1'b1, sdms_pkg::ADR_INT_STAT, 32'h7, rd);
        xfer(1'b1, sdms_pkg::ADR_INT_MASK, 32'h1, rd);
        xfer(1'b1, sdms_pkg::ADR_CTRL, 32'h85, rd);
        ctl_u.pulse(1'b0, 4);
        exp_cnt = exp_cnt + 10'h200;
        settle();
        chk_bit(standstill_o, 1'b0);
        chk_bit(irq_o, 1'b0);
        chk_bit(ramp_off_o, 1'b0);
        chk_word(32'(current_scale_o), 32'h0a);
        wait_stst(16);
        settle();
        chk_bit(irq_o, 1'b1);
        xfer(1'b1, sdms_pkg::ADR_INT_STAT, 32'h1, rd);
        settle();
        chk_bit(irq_o, 1'b0);
        // interpolation: rising rate skips leftovers, final position exact
        xfer(1'b1, sdms_pkg::ADR_CTRL, 32'h82, rd);
        xfer(1'b1, sdms_pkg::ADR_INT_STAT, 32'h7, rd);
        repeat (3) ctl_u.pulse(1'b0, 20);
        exp_cnt = exp_cnt + 10'h300;
        chk_bit(mscnt_o == exp_cnt, 1'b0);
        repeat (300) @(posedge clk_i);
        settle();
        chk_word(32'(mscnt_o), 32'(exp_cnt));
        xfer(1'b0, sdms_pkg::ADR_INT_STAT, 32'h0, rd);
        chk_word(rd & 32'h4, 32'h4);
        report_and_stop();
    end
endmodule : sdms_sequencer_tb_top

// ---- sdms_stepgen.sv ----
// partner model: external motion controller driving the step and direction pins
`timescale 1ns/1ns

module sdms_stepgen (
    input  wire logic clk_i,   // system clock
    output logic      step_o,  // step pin
    output logic      dir_o    // direction pin
);
    // ****************************************************************
    // pulse generation
    // ****************************************************************
    // pins idle low until the first command
    initial begin
        step_o = 1'b0;
        dir_o  = 1'b0;
    end

    // one step pulse; high for h cycles, then low for h, and back to back the next rise comes h+3 cycles after the fall
    task automatic pulse(input logic d, input int half);
        int h;
        h = (half < 2) ? 2 : half;
        @(posedge clk_i);
        dir_o <= d;
        repeat (2) @(posedge clk_i);
        step_o <= 1'b1;
        repeat (h) @(posedge clk_i);
        step_o <= 1'b0;
        repeat (h) @(posedge clk_i);
    endtask : pulse
endmodule : sdms_stepgen
